/* File: hw/uiosc_consts.vh */
// Offsets, fields and reset values of the user I/O block.
// Included by the design files; holds definitions only.
`ifndef UIOSC_CONSTS_VH
`define UIOSC_CONSTS_VH

// Register byte offsets.
`define UIOSC_ADDR_CTRL 6'h00
`define UIOSC_ADDR_IOCFG 6'h04
`define UIOSC_ADDR_BRIGHT 6'h08
`define UIOSC_ADDR_THRESH 6'h0c
`define UIOSC_ADDR_AWCAL 6'h10
`define UIOSC_ADDR_VCAL 6'h14
`define UIOSC_ADDR_HOME 6'h18
`define UIOSC_ADDR_STATUS 6'h1c
`define UIOSC_ADDR_READING 6'h20
`define UIOSC_ADDR_MOVE 6'h24

// Control register fields.
`define UIOSC_CTRL_SRC 0
`define UIOSC_CTRL_CUNIT 2:1
`define UIOSC_CTRL_VUNIT 4:3
`define UIOSC_CTRL_HV1 5
`define UIOSC_CTRL_HV2 6
`define UIOSC_CTRL_WHEEL 8:7
`define UIOSC_CTRL_PERSIST 9
`define UIOSC_CTRL_TRACK 10
`define UIOSC_CTRL_MASK 32'h0000_05ff

// I/O configuration fields: connector n uses bits 4n+2..4n and 4n+3.
`define UIOSC_IOCFG_GPO1 8
`define UIOSC_IOCFG_GPO2 9
`define UIOSC_IOCFG_MASK 32'h0000_03ff

// Connector modes.
`define UIOSC_MODE_DIS 3'h0
`define UIOSC_MODE_GPIN 3'h1
`define UIOSC_MODE_TRKIN 3'h2
`define UIOSC_MODE_HOMEIN 3'h3
`define UIOSC_MODE_GPOUT 3'h4
`define UIOSC_MODE_TRKOUT 3'h5
`define UIOSC_MODE_ANALOG 3'h6

// Unit modes.
`define UIOSC_CUNIT_AMPS 2'h0
`define UIOSC_CUNIT_WATTS 2'h1
`define UIOSC_CUNIT_DB 2'h2
`define UIOSC_VUNIT_VOLTS 2'h0
`define UIOSC_VUNIT_PCT 2'h1
`define UIOSC_VUNIT_USER 2'h2

// Reset values.
`define UIOSC_RST_CTRL 32'h0000_0080
`define UIOSC_RST_IOCFG 32'h0000_0088
`define UIOSC_RST_BRIGHT 8'h80
`define UIOSC_RST_THRESH 16'h0100
`define UIOSC_RST_AWCAL 16'h0100
`define UIOSC_RST_VCAL 16'h0001
`define UIOSC_RST_HOME 32'h8000_8000

// Input span in millivolts; percent full scale.
`define UIOSC_EXT_SPAN_MV 16'd2000
`define UIOSC_PCT_FULL 7'd100

`endif

/* File: hw/uiosc_sync.v */
// Two-stage synchroniser for the digital user connector levels.
// Assumes asynchronous pin levels; the output is on ref_clk_in.
`timescale 1ns/100ps
module uiosc_sync (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_b_in,
    // Levels.
    input wire [1:0] async_in,
    output wire [1:0] sync_out
);
    reg [1:0] meta_q;
    reg [1:0] sync_q;
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_bit
            always @(posedge ref_clk_in) begin
                if (!rst_b_in) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    assign sync_out = sync_q;
endmodule

/* File: hw/uiosc_reading.v */
// Unit conversion of the feedback sample into the reported reading.
// Assumes the sample is on ref_clk_in; full scale 16'hffff.
`timescale 1ns/100ps
`include "uiosc_consts.vh"
module uiosc_reading (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_b_in,
    // Configuration.
    input wire src_ext_in,
    input wire [1:0] cur_unit_in,
    input wire [1:0] volt_unit_in,
    input wire [15:0] aw_cal_in,
    input wire [15:0] v_cal_in,
    // Sample and result.
    input wire [15:0] sample_in,
    output wire [31:0] reading_out
);
    reg [31:0] reading_q;
    reg [31:0] reading_d;
    wire [31:0] watts_prod;
    wire [22:0] pct_prod;
    wire [31:0] user_prod;
    wire [4:0] msb_pos;

    // A scale factor of 1/(A/W) in 8.8 form avoids a divider.
    assign watts_prod = sample_in * aw_cal_in;
    assign pct_prod = sample_in * `UIOSC_PCT_FULL;
    assign user_prod = sample_in * v_cal_in;

    // Integer log2 of the power gives about 3 dB per step.
    function [4:0] msb_of;
        input [31:0] v;
        integer k;
        begin
            msb_of = 5'h00;
            for (k = 0; k < 32; k = k + 1) begin
                if (v[k]) begin
                    msb_of = k[4:0];
                end
            end
        end
    endfunction
    assign msb_pos = msb_of(watts_prod);

    always @* begin
        reading_d = {16'h0000, sample_in};
        if (!src_ext_in) begin
            case (cur_unit_in)
                `UIOSC_CUNIT_WATTS: reading_d = {8'h00, watts_prod[31:8]};
                `UIOSC_CUNIT_DB: reading_d = {25'h0, msb_pos, 2'b00}
                    - {27'h0, msb_pos};
                default: reading_d = {16'h0000, sample_in};
            endcase
        end else begin
            case (volt_unit_in)
                `UIOSC_VUNIT_PCT: reading_d = {25'h0, pct_prod[22:16]};
                `UIOSC_VUNIT_USER: reading_d = {16'h0000, user_prod[31:16]};
                default: reading_d = {16'h0000, sample_in};
            endcase
        end
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            reading_q <= 32'h0000_0000;
        end else begin
            reading_q <= reading_d;
        end
    end
    assign reading_out = reading_q;
endmodule

/* File: hw/uiosc_top.v */
// Feedback source, unit, drive range and user connector configuration
// with an AXI4-Lite register slave.
// Assumes samples arrive on ref_clk_in and connector pins are asynchronous.
//
// Contract
// - Select amplifier or external voltage feedback.
// - Amplifier source routes amplifier, enables autoranging.
// - External source bypasses amplifier, no ranging, 2V.
// - Amplifier readings in mA, mW or dB.
// - Voltage readings in volts or percent.
// - User mode reading is fraction times calibration.
// - Each drive output range 75V or 150V.
// - Connector one analog in, two analog out.
// - Disabled mode neither drives nor acts.
// - General input level readable by software.
// - Trigger level selects tracking or latch.
// - Home trigger moves circle to home position.
// - General output drives software written level.
// - Tracking output asserts above threshold.
// - Analog modes: feedback input, feedback monitor.
// - External source forces connector one analog; here only on register writes, not on a restore from the persistent store.
// - Monitor output follows relative range signal.
// - Polarity setting inverts digital connector level.
// - Display brightness accepted from 0 to 255.
// - Thumbwheel step low, mid or high.
// - Persisted settings stored and restored at power-up.
// - Manual moves accepted in latch and tracking.
// - Tracking indication when level exceeds threshold.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "uiosc_consts.vh"
module uiosc_top (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_b_in,
    // Write address and data.
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // Write response.
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    // Read.
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [5:0] s_axi_araddr,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // Feedback samples.
    input wire [15:0] amp_sample_in,
    input wire [15:0] ext_sample_in,
    input wire [15:0] rel_signal_in,
    // Feedback path control.
    output wire amp_route_out,
    output wire autorange_en_out,
    output wire [15:0] ext_span_mv_out,
    output wire feedback_analog_input_out,
    output wire feedback_monitor_en_out,
    output wire [15:0] feedback_monitor_output_out,
    // Settings.
    output wire drive_output_one_hi_out,
    output wire drive_output_two_hi_out,
    output wire [7:0] bright_out,
    output wire [1:0] wheel_step_out,
    // Tracking and circle moves.
    output wire track_mode_out,
    output wire tracking_active_out,
    output wire move_valid_out,
    output wire [15:0] move_x_out,
    output wire [15:0] move_y_out,
    // User connector pins.
    input wire user_connector_one_in,
    output wire user_connector_one_out,
    output wire user_connector_one_oe_out,
    input wire user_connector_two_in,
    output wire user_connector_two_out,
    output wire user_connector_two_oe_out,
    // Persistent store.
    output wire nv_store_out,
    output wire [31:0] nv_ctrl_out,
    output wire [31:0] nv_iocfg_out,
    input wire nv_load_in,
    input wire [31:0] nv_ctrl_in,
    input wire [31:0] nv_iocfg_in
);
    reg [31:0] ctrl_q, iocfg_q, home_q, wdata_q, rdata_q, rdata_d;
    reg [15:0] thresh_q, awcal_q, vcal_q, move_x_q, move_y_q, monitor_q;
    reg [7:0] bright_q;
    reg [5:0] awaddr_q;
    reg [3:0] wstrb_q;
    reg [1:0] bresp_q, rresp_q, pin_q, oe_q, home_prev_q;
    reg aw_held_q, w_held_q, bvalid_q, rvalid_q, rmapped_d, nv_store_q;
    reg move_valid_q, track_mode_q, above_q;
    wire [31:0] wmask, wmerge_ctrl, wmerge_io, wmerge_home, wmerge_misc;
    wire [31:0] reading;
    wire [15:0] fb_level;
    wire [5:0] mode_all, status;
    wire [1:0] lvl_sync, active, trk_en, home_en, gp_out, pol;
    wire do_write, wmapped, src_ext, home_go, sw_move;

    // Write address and data are held separately until both are here.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wmapped = awaddr_q[5:2] <= `UIOSC_ADDR_MOVE >> 2;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wmerge_ctrl = (ctrl_q & ~wmask) | (wdata_q & wmask);
    assign wmerge_io = (iocfg_q & ~wmask) | (wdata_q & wmask);
    assign wmerge_home = (home_q & ~wmask) | (wdata_q & wmask);
    assign wmerge_misc = wdata_q & wmask;
    assign sw_move = do_write && awaddr_q == `UIOSC_ADDR_MOVE;

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wmapped ? 2'b00 : 2'b10;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register file; a restore from the persistent store wins over a write.
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ctrl_q <= `UIOSC_RST_CTRL;
            iocfg_q <= `UIOSC_RST_IOCFG;
            bright_q <= `UIOSC_RST_BRIGHT;
            thresh_q <= `UIOSC_RST_THRESH;
            awcal_q <= `UIOSC_RST_AWCAL;
            vcal_q <= `UIOSC_RST_VCAL;
            home_q <= `UIOSC_RST_HOME;
            nv_store_q <= 1'b0;
        end else begin
            nv_store_q <= 1'b0;
            if (nv_load_in) begin
                ctrl_q <= nv_ctrl_in & `UIOSC_CTRL_MASK & ~32'h0000_0200;
                iocfg_q <= nv_iocfg_in & `UIOSC_IOCFG_MASK;
            end else if (do_write) begin
                case (awaddr_q)
                    `UIOSC_ADDR_CTRL: begin
                        ctrl_q <= wmerge_ctrl & `UIOSC_CTRL_MASK
                            & ~32'h0000_0200;
                        nv_store_q <= wmerge_ctrl[`UIOSC_CTRL_PERSIST];
                        if (wmerge_ctrl[`UIOSC_CTRL_SRC]) begin
                            iocfg_q[2:0] <= `UIOSC_MODE_ANALOG;
                        end
                    end
                    `UIOSC_ADDR_IOCFG: begin
                        iocfg_q <= wmerge_io & `UIOSC_IOCFG_MASK;
                        if (ctrl_q[`UIOSC_CTRL_SRC]) begin
                            iocfg_q[2:0] <= `UIOSC_MODE_ANALOG;
                        end
                    end
                    `UIOSC_ADDR_BRIGHT: bright_q <= wmerge_misc[7:0];
                    `UIOSC_ADDR_THRESH: thresh_q <= wmerge_misc[15:0];
                    `UIOSC_ADDR_AWCAL: awcal_q <= wmerge_misc[15:0];
                    `UIOSC_ADDR_VCAL: vcal_q <= wmerge_misc[15:0];
                    `UIOSC_ADDR_HOME: home_q <= wmerge_home;
                    default: nv_store_q <= 1'b0;
                endcase
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    assign s_axi_arready = !rvalid_q;
    assign status = {above_q, track_mode_q, active, lvl_sync};
    always @* begin
        rdata_d = 32'h0000_0000;
        rmapped_d = 1'b1;
        case (s_axi_araddr)
            `UIOSC_ADDR_CTRL: rdata_d = ctrl_q;
            `UIOSC_ADDR_IOCFG: rdata_d = iocfg_q;
            `UIOSC_ADDR_BRIGHT: rdata_d = {24'h000000, bright_q};
            `UIOSC_ADDR_THRESH: rdata_d = {16'h0000, thresh_q};
            `UIOSC_ADDR_AWCAL: rdata_d = {16'h0000, awcal_q};
            `UIOSC_ADDR_VCAL: rdata_d = {16'h0000, vcal_q};
            `UIOSC_ADDR_HOME: rdata_d = home_q;
            `UIOSC_ADDR_STATUS: rdata_d = {26'h0, status};
            `UIOSC_ADDR_READING: rdata_d = reading;
            `UIOSC_ADDR_MOVE: rdata_d = {move_y_q, move_x_q};
            default: rmapped_d = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rdata_d;
            rresp_q <= rmapped_d ? 2'b00 : 2'b10;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Feedback source selection and derived path controls.
    assign src_ext = ctrl_q[`UIOSC_CTRL_SRC];
    assign amp_route_out = !src_ext;
    assign autorange_en_out = !src_ext;
    assign ext_span_mv_out = `UIOSC_EXT_SPAN_MV;
    assign fb_level = src_ext ? ext_sample_in : amp_sample_in;

    uiosc_reading u_reading (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .src_ext_in(src_ext),
        .cur_unit_in(ctrl_q[`UIOSC_CTRL_CUNIT]),
        .volt_unit_in(ctrl_q[`UIOSC_CTRL_VUNIT]),
        .aw_cal_in(awcal_q),
        .v_cal_in(vcal_q),
        .sample_in(fb_level),
        .reading_out(reading)
    );

    // Pin levels are asynchronous, so they are synchronised first.
    uiosc_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .async_in({user_connector_two_in, user_connector_one_in}),
        .sync_out(lvl_sync)
    );

    assign mode_all = {iocfg_q[6:4], iocfg_q[2:0]};
    assign pol = {iocfg_q[7], iocfg_q[3]};
    assign gp_out = {iocfg_q[`UIOSC_IOCFG_GPO2], iocfg_q[`UIOSC_IOCFG_GPO1]};

    // Per-connector decode; disabled and analog modes never drive digitally.
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_conn
            wire [2:0] mode;
            assign mode = mode_all[3*c+2:3*c];
            assign active[c] = pol[c] ? lvl_sync[c] : !lvl_sync[c];
            assign trk_en[c] = mode == `UIOSC_MODE_TRKIN;
            assign home_en[c] = mode == `UIOSC_MODE_HOMEIN;
            always @(posedge ref_clk_in) begin
                if (!rst_b_in) begin
                    pin_q[c] <= 1'b0;
                    oe_q[c] <= 1'b0;
                    home_prev_q[c] <= 1'b0;
                end else begin
                    home_prev_q[c] <= home_en[c] && active[c];
                    case (mode)
                        `UIOSC_MODE_GPOUT: begin
                            pin_q[c] <= pol[c] ? gp_out[c] : !gp_out[c];
                            oe_q[c] <= 1'b1;
                        end
                        `UIOSC_MODE_TRKOUT: begin
                            pin_q[c] <= pol[c] ? above_q : !above_q;
                            oe_q[c] <= 1'b1;
                        end
                        default: begin
                            pin_q[c] <= 1'b0;
                            oe_q[c] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    assign home_go = |(home_en & active & ~home_prev_q);

    // Tracking state, threshold compare, monitor and circle moves.
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            track_mode_q <= 1'b0;
            above_q <= 1'b0;
            monitor_q <= 16'h0000;
            move_valid_q <= 1'b0;
            move_x_q <= 16'h0000;
            move_y_q <= 16'h0000;
        end else begin
            above_q <= fb_level > thresh_q;
            monitor_q <= feedback_monitor_en_out ?
                rel_signal_in : 16'h0000;
            if (trk_en[0]) begin
                track_mode_q <= active[0];
            end else if (trk_en[1]) begin
                track_mode_q <= active[1];
            end else begin
                track_mode_q <= ctrl_q[`UIOSC_CTRL_TRACK];
            end
            move_valid_q <= home_go || sw_move;
            if (home_go) begin
                move_x_q <= home_q[15:0];
                move_y_q <= home_q[31:16];
            end else if (sw_move) begin
                move_x_q <= wdata_q[15:0];
                move_y_q <= wdata_q[31:16];
            end
        end
    end

    // Analog modes belong to one connector each.
    assign feedback_analog_input_out =
        mode_all[2:0] == `UIOSC_MODE_ANALOG;
    assign feedback_monitor_en_out =
        mode_all[5:3] == `UIOSC_MODE_ANALOG;
    assign feedback_monitor_output_out = monitor_q;

    assign drive_output_one_hi_out = ctrl_q[`UIOSC_CTRL_HV1];
    assign drive_output_two_hi_out = ctrl_q[`UIOSC_CTRL_HV2];
    assign bright_out = bright_q;
    assign wheel_step_out = ctrl_q[`UIOSC_CTRL_WHEEL];
    assign track_mode_out = track_mode_q;
    assign tracking_active_out = above_q;
    assign move_valid_out = move_valid_q;
    assign move_x_out = move_x_q;
    assign move_y_out = move_y_q;
    assign user_connector_one_out = pin_q[0];
    assign user_connector_one_oe_out = oe_q[0];
    assign user_connector_two_out = pin_q[1];
    assign user_connector_two_oe_out = oe_q[1];
    assign nv_store_out = nv_store_q;
    assign nv_ctrl_out = ctrl_q;
    assign nv_iocfg_out = iocfg_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

/* File: dv/uiosc_chk_sva.sv */
// Checker for the user I/O block, bound to the top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/100ps
module uiosc_chk (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_b_in,
    // Bus handshakes.
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_arready,
    // Feedback path.
    input wire amp_route_out,
    input wire autorange_en_out,
    input wire [15:0] ext_span_mv_out,
    input wire feedback_analog_input_out,
    input wire feedback_monitor_en_out,
    input wire [15:0] feedback_monitor_output_out,
    input wire [15:0] rel_signal_in,
    // Pins and events.
    input wire user_connector_one_oe_out,
    input wire move_valid_out,
    input wire nv_store_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_span; ext_span_mv_out == 16'h07d0; endproperty
    a_span: assert property (p_span) else $error("span wrong");
    property p_route; amp_route_out == autorange_en_out; endproperty
    a_route: assert property (p_route) else $error("ranging");
    property p_ext; !amp_route_out |-> feedback_analog_input_out; endproperty
    a_ext: assert property (p_ext) else $error("ext mode");
    property p_mon;
        feedback_monitor_en_out && $past(feedback_monitor_en_out) |->
            feedback_monitor_output_out == $past(rel_signal_in);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor");
    property p_monz;
        !feedback_monitor_en_out && !$past(feedback_monitor_en_out) |->
            feedback_monitor_output_out == 16'h0000;
    endproperty
    a_monz: assert property (p_monz) else $error("monitor idle");
    property p_in1;
        feedback_analog_input_out [*2] |-> !user_connector_one_oe_out;
    endproperty
    a_in1: assert property (p_in1) else $error("analog drives");
    property p_mv; move_valid_out |=> !move_valid_out; endproperty
    a_mv: assert property (p_mv) else $error("move pulse");
    property p_nv; nv_store_out |=> !nv_store_out; endproperty
    a_nv: assert property (p_nv) else $error("store pulse");
    property p_bv; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bv: assert property (p_bv) else $error("bvalid stuck");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("arready");
    c_move: cover property (move_valid_out);
    c_store: cover property (nv_store_out);
    c_ext: cover property (!amp_route_out);
    c_mon: cover property (feedback_monitor_en_out);
endmodule
bind uiosc_top uiosc_chk u_chk (.*);

/* File: dv/uiosc_ttl_model.sv */
// External TTL equipment on the two user connectors.
// Assumes levels are set by the bench just after a clock edge.
`timescale 1ns/100ps
module uiosc_ttl_model (
    input wire ref_clk_in,
    input wire [1:0] dev_lvl_in,
    input wire [1:0] dev_oe_in,
    input wire [1:0] drv_lvl_in,
    input wire [1:0] drv_en_in,
    output logic [1:0] pin_out
);
    logic [1:0] flip_q = 2'h0;
    // A floating line wanders, so a design acting on it is caught.
    always @(posedge ref_clk_in) flip_q <= ~flip_q;
    assign pin_out = dev_oe_in & dev_lvl_in | ~dev_oe_in &
        (drv_en_in & drv_lvl_in | ~drv_en_in & flip_q);
endmodule

/* File: dv/test_uiosc.sv */
// Register-level bench for the user I/O block.
// Assumes an AXI4-Lite master and TTL equipment on both connectors.
`timescale 1ns/100ps
module test_uiosc;
    logic ref_clk_in = 1'h0, rst_b_in = 1'h0, nv_load_in = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
    logic [31:0] s_axi_wdata = 32'h0, nv_ctrl_in = 32'h0, nv_iocfg_in = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] amp_sample_in = 16'h0, ext_sample_in = 16'h0;
    logic [15:0] rel_signal_in = 16'h0;
    logic [1:0] drv_lvl = 2'h0, drv_en = 2'h0, resp;
    logic [31:0] rdat, mv_xy = 32'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, amp_route_out, autorange_en_out, move_valid_out;
    wire [1:0] s_axi_bresp, s_axi_rresp, wheel_step_out;
    wire [31:0] s_axi_rdata, nv_ctrl_out, nv_iocfg_out;
    wire [15:0] ext_span_mv_out, feedback_monitor_output_out;
    wire [15:0] move_x_out, move_y_out;
    wire [7:0] bright_out;
    wire feedback_analog_input_out, feedback_monitor_en_out, nv_store_out;
    wire drive_output_one_hi_out, drive_output_two_hi_out;
    wire track_mode_out, tracking_active_out;
    wire user_connector_one_out, user_connector_one_oe_out;
    wire user_connector_two_out, user_connector_two_oe_out;
    wire user_connector_one_in, user_connector_two_in;
    int n_fail = 0, check_count = 0, i, nv_n = 0;
    logic [31:0] rstv [7] = '{32'h80, 32'h88, 32'h80, 32'h100, 32'h100,
        32'h1, 32'h80008000};
    logic [31:0] vexp [3] = '{32'h8000, 32'h32, 32'ha};
    logic [31:0] cexp [3] = '{32'h100, 32'h200, 32'h33};
    uiosc_top u_dut (.*);
    uiosc_ttl_model u_ttl (.ref_clk_in(ref_clk_in),
        .dev_lvl_in({user_connector_two_out, user_connector_one_out}),
        .dev_oe_in({user_connector_two_oe_out, user_connector_one_oe_out}),
        .drv_lvl_in(drv_lvl), .drv_en_in(drv_en),
        .pin_out({user_connector_two_in, user_connector_one_in}));
    initial forever #20 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (move_valid_out) mv_xy <= {move_y_out, move_x_out};
        if (nv_store_out) nv_n <= nv_n + 1;
    end
    task chk(input string n, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp; s_axi_bready <= 1'h0;
        @(posedge ref_clk_in);
    endtask
    task rd(input [5:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 1'h0;
        @(posedge ref_clk_in);
    endtask
    task rc(input [5:0] a, input [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    task pins(input [1:0] l);
        drv_lvl <= l;
        repeat (6) @(posedge ref_clk_in);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        @(posedge ref_clk_in);
        for (i = 0; i < 7; i++) rc(6'(i * 4), rstv[i]);
        chk("wheel", 1, wheel_step_out);
        wr(6'h08, 32'h0); chk("bright", 0, bright_out);
        wr(6'h08, 32'hff); rc(6'h08, 32'hff);
        for (i = 0; i < 3; i++) begin
            wr(6'h00, (i << 7) | (32'h20 << (i & 1)));
            chk("wheel", i, wheel_step_out);
            chk("hv1", ~i & 1, drive_output_one_hi_out);
            chk("hv2", i & 1, drive_output_two_hi_out);
        end
        $display("test settings done");
        wr(6'h04, 32'h3cc); chk("out1", 3, {user_connector_one_oe_out,
            user_connector_one_out});
        chk("out2", 1, user_connector_two_out);
        wr(6'h04, 32'h104); chk("pol", 0, user_connector_one_out);
        wr(6'h04, 32'h80); chk("dis", 0, user_connector_one_oe_out);
        wr(6'h04, 32'h98); drv_en <= 2'h3; pins(2'h2);
        rd(6'h1c); chk("gpin", 1, rdat[1]);
        pins(2'h0); rd(6'h1c); chk("gpin", 0, rdat[1]);
        wr(6'h04, 32'h8a); pins(2'h1); chk("trk", 1, track_mode_out);
        pins(2'h0); chk("latch", 0, track_mode_out);
        wr(6'h04, 32'h82); pins(2'h0); chk("inv", 1, track_mode_out);
        wr(6'h24, 32'h50006); pins(2'h0); chk("mv", 32'h50006, mv_xy);
        wr(6'h18, 32'h120034); wr(6'h04, 32'h8b); pins(2'h1);
        chk("home", 32'h120034, mv_xy);
        wr(6'h24, 32'h70008); pins(2'h1); chk("mv", 32'h70008, mv_xy);
        $display("test connectors done");
        wr(6'h00, 32'h280); rc(6'h00, 32'h80); chk("store", 1, nv_n);
        nv_ctrl_in <= 32'h60; nv_iocfg_in <= 32'h88; nv_load_in <= 1'h1;
        @(posedge ref_clk_in);
        nv_load_in <= 1'h0;
        @(posedge ref_clk_in);
        rc(6'h00, 32'h60); rc(6'h04, 32'h88);
        wr(6'h04, 32'he8); rel_signal_in <= 16'h1234; pins(2'h0);
        chk("mon", 32'h1234, feedback_monitor_output_out);
        ext_sample_in <= 16'h8000; wr(6'h14, 32'h14);
        for (i = 0; i < 3; i++) begin
            wr(6'h00, 32'h1 | (i << 3)); rc(6'h20, vexp[i]);
        end
        chk("route", 0, {amp_route_out, autorange_en_out});
        rc(6'h04, 32'hee);
        amp_sample_in <= 16'h100; wr(6'h10, 32'h200);
        for (i = 0; i < 3; i++) begin
            wr(6'h00, i << 1); rc(6'h20, cexp[i]);
        end
        chk("route", 3, {amp_route_out, autorange_en_out});
        wr(6'h04, 32'hd8); amp_sample_in <= 16'h180; pins(2'h0);
        chk("above", 3, {tracking_active_out, user_connector_two_out});
        amp_sample_in <= 16'h80; pins(2'h0);
        chk("below", 0, tracking_active_out);
        rd(6'h28); chk("rresp", 2, resp);
        wr(6'h28, 32'h1); chk("bresp", 2, resp);
        $display("test feedback done");
        end_of_test;
    end
endmodule
